//--- rtl/external_bus_strobe_sequencer.sv
// External memory bus phase sequencer: latch, setup, strobe and hold phases
`default_nettype none
`include "ebus_seq_params.svh"

module external_bus_strobe_sequencer #(
  parameter int CNT_W = `EBUS_CNT_W,
  parameter int ADDR_W = `EBUS_ADDR_W,
  parameter int DATA_W = `EBUS_DATA_W,
  parameter int LANE_W = `EBUS_LANE_W,
  parameter int FIFO_DEPTH = `EBUS_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqPageHit,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqWriteData,
  input wire logic [LANE_W-1:0] reqByteLanes,
  output logic accessDone,
  output logic [DATA_W-1:0] readData,
  output logic busy,
  input wire ebus_seq_pkg::addr_mode_t addrMode,
  input wire logic pageModeEnable,
  input wire logic flashStrobeSelect,
  input wire logic readyWaitEnable,
  input wire logic [CNT_W-1:0] write_setup_cycles,
  input wire logic [CNT_W-1:0] write_strobe_cycles,
  input wire logic [CNT_W-1:0] write_hold_cycles,
  input wire logic half_write_strobe,
  input wire logic [CNT_W-1:0] read_setup_cycles,
  input wire logic [CNT_W-1:0] read_strobe_cycles,
  input wire logic [CNT_W-1:0] read_hold_cycles,
  input wire logic half_read_strobe,
  input wire logic [CNT_W-1:0] page_hit_strobe_cycles,
  input wire logic [CNT_W-1:0] latch_strobe_cycles,
  input wire logic [CNT_W-1:0] latch_hold_cycles,
  input wire logic half_latch_strobe,
  output logic write_strobe_out_n,
  output logic flash_write_strobe_out_n,
  output logic read_strobe_out_n,
  output logic flash_read_strobe_out_n,
  output logic latch_strobe_out,
  output logic [DATA_W-1:0] shared_addr_data_lines_out,
  output logic shared_addr_data_lines_oe,
  input wire logic [DATA_W-1:0] shared_addr_data_lines_in,
  output logic [ADDR_W-1:0] upper_addr_lines,
  output logic chip_select_out_n,
  output logic [LANE_W-1:0] byte_lane_out_n,
  input wire logic ready_wait_in,
  output logic strobeLeadHalfDelay,
  output logic latchTrailHalfEarly
);
  import ebus_seq_pkg::*;

  localparam int REQ_W = 2 + LANE_W + ADDR_W + DATA_W;

  logic [REQ_W-1:0] fifoIn, fifoOut;
  logic fifoValid, fifoPop;

  ebus_req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) reqFifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData(fifoIn),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  // Pin inputs pass two flops before any logic looks at them
  logic readyMeta_reg, readySync_reg;
  logic [DATA_W-1:0] dataMeta_reg, dataSync_reg;

  phase_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic isWrite_reg, isWrite_next, pageHit_reg, pageHit_next;
  logic [LANE_W-1:0] lanes_reg, lanes_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic accessDone_reg, accessDone_next;
  logic [DATA_W-1:0] readData_reg, readData_next;
  logic wrStb_reg, wrStb_next, fwrStb_reg, fwrStb_next;
  logic rdStb_reg, rdStb_next, frdStb_reg, frdStb_next;
  logic latch_reg, latch_next;
  logic [DATA_W-1:0] shOut_reg, shOut_next;
  logic shOe_reg, shOe_next;
  logic [ADDR_W-1:0] upper_reg, upper_next;
  logic cs_reg, cs_next;
  logic [LANE_W-1:0] bl_reg, bl_next;
  logic busy_reg, busy_next;
  logic halfLead_reg, halfLead_next, halfTrail_reg, halfTrail_next;
  logic [CNT_W-1:0] setupCnt, strobeCnt, holdCnt;
  logic muxMode, strobeFirst;

  always_comb begin
    fifoIn = {reqWrite, reqPageHit, reqByteLanes, reqAddr, reqWriteData};
  end

  // Phase sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    {isWrite_next, pageHit_next, lanes_next, addr_next, wdata_next} =
      {isWrite_reg, pageHit_reg, lanes_reg, addr_reg, wdata_reg};
    fifoPop = 1'b0;
    accessDone_next = 1'b0;
    readData_next = readData_reg;
    strobeFirst = 1'b0;
    if (state_reg == ST_IDLE && fifoValid) begin
      fifoPop = 1'b1;
      {isWrite_next, pageHit_next, lanes_next, addr_next, wdata_next} = fifoOut;
    end
    muxMode = addrMode != ADDR_MODE_PLAIN;
    setupCnt = isWrite_next ? write_setup_cycles : read_setup_cycles;
    holdCnt = isWrite_next ? write_hold_cycles : read_hold_cycles;
    strobeCnt = isWrite_next ? write_strobe_cycles : read_strobe_cycles;
    if (!isWrite_next && pageModeEnable && pageHit_next) begin
      strobeCnt = page_hit_strobe_cycles;
    end
    case (state_reg)
      ST_IDLE: begin
        if (fifoValid) begin
          if (muxMode) begin
            state_next = ST_LATCH;
            cnt_next = latch_strobe_cycles;
          end else if (setupCnt != '0) begin
            state_next = ST_SETUP;
            cnt_next = setupCnt - 1'b1;
          end else begin
            state_next = ST_STROBE;
            cnt_next = strobeCnt;
            strobeFirst = 1'b1;
          end
        end
      end
      ST_LATCH: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (isWrite_reg && latch_hold_cycles != '0) begin
          state_next = ST_LATCH_HOLD;
          cnt_next = latch_hold_cycles - 1'b1;
        end else if (setupCnt != '0) begin
          state_next = ST_SETUP;
          cnt_next = setupCnt - 1'b1;
        end else begin
          state_next = ST_STROBE;
          cnt_next = strobeCnt;
          strobeFirst = 1'b1;
        end
      end
      ST_LATCH_HOLD, ST_SETUP: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (state_reg == ST_LATCH_HOLD && setupCnt != '0) begin
          state_next = ST_SETUP;
          cnt_next = setupCnt - 1'b1;
        end else begin
          state_next = ST_STROBE;
          cnt_next = strobeCnt;
          strobeFirst = 1'b1;
        end
      end
      ST_STROBE: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (!readyWaitEnable || readySync_reg) begin
          if (!isWrite_reg) begin
            readData_next = dataSync_reg;
          end
          if (holdCnt != '0) begin
            state_next = ST_HOLD;
            cnt_next = holdCnt - 1'b1;
          end else begin
            state_next = ST_IDLE;
            accessDone_next = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          state_next = ST_IDLE;
          accessDone_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the next phase so each pin leaves a flop
  always_comb begin
    wrStb_next = `EBUS_STROBE_IDLE;
    fwrStb_next = `EBUS_STROBE_IDLE;
    rdStb_next = `EBUS_STROBE_IDLE;
    frdStb_next = `EBUS_STROBE_IDLE;
    latch_next = `EBUS_LATCH_IDLE;
    cs_next = `EBUS_SELECT_IDLE;
    bl_next = '1;
    shOut_next = shOut_reg;
    shOe_next = 1'b0;
    upper_next = upper_reg;
    halfLead_next = 1'b0;
    halfTrail_next = 1'b0;
    busy_next = state_next != ST_IDLE;
    if (state_next != ST_IDLE) begin
      cs_next = !`EBUS_SELECT_IDLE;
      bl_next = ~lanes_next;
      upper_next = addr_next;
      shOe_next = isWrite_next;
      shOut_next = wdata_next;
    end
    case (state_next)
      ST_LATCH: begin
        latch_next = !`EBUS_LATCH_IDLE;
        shOe_next = 1'b1;
        shOut_next = addr_next[DATA_W-1:0];
        // Pad stage pulls the trailing edge in using the fast clock
        halfTrail_next = half_latch_strobe && cnt_next == '0;
      end
      ST_LATCH_HOLD: begin
        shOe_next = 1'b1;
        shOut_next = addr_next[DATA_W-1:0];
      end
      ST_SETUP: begin
        if (!isWrite_next && muxMode) begin
          shOe_next = 1'b1;
          shOut_next = addr_next[DATA_W-1:0];
        end
      end
      ST_STROBE: begin
        if (isWrite_next) begin
          wrStb_next = flashStrobeSelect ? `EBUS_STROBE_IDLE : !`EBUS_STROBE_IDLE;
          fwrStb_next = flashStrobeSelect ? !`EBUS_STROBE_IDLE : `EBUS_STROBE_IDLE;
          halfLead_next = half_write_strobe && strobeFirst;
        end else begin
          rdStb_next = flashStrobeSelect ? `EBUS_STROBE_IDLE : !`EBUS_STROBE_IDLE;
          frdStb_next = flashStrobeSelect ? !`EBUS_STROBE_IDLE : `EBUS_STROBE_IDLE;
          halfLead_next = half_read_strobe && strobeFirst;
        end
      end
      default: begin
        latch_next = `EBUS_LATCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readyMeta_reg <= 1'b0;
      readySync_reg <= 1'b0;
      dataMeta_reg <= '0;
      dataSync_reg <= '0;
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      isWrite_reg <= 1'b0;
      pageHit_reg <= 1'b0;
      lanes_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      accessDone_reg <= 1'b0;
      readData_reg <= '0;
      wrStb_reg <= `EBUS_STROBE_IDLE;
      fwrStb_reg <= `EBUS_STROBE_IDLE;
      rdStb_reg <= `EBUS_STROBE_IDLE;
      frdStb_reg <= `EBUS_STROBE_IDLE;
      latch_reg <= `EBUS_LATCH_IDLE;
      shOut_reg <= '0;
      shOe_reg <= 1'b0;
      upper_reg <= '0;
      cs_reg <= `EBUS_SELECT_IDLE;
      bl_reg <= '1;
      busy_reg <= 1'b0;
      halfLead_reg <= 1'b0;
      halfTrail_reg <= 1'b0;
    end else begin
      readyMeta_reg <= ready_wait_in;
      readySync_reg <= readyMeta_reg;
      dataMeta_reg <= shared_addr_data_lines_in;
      dataSync_reg <= dataMeta_reg;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      isWrite_reg <= isWrite_next;
      pageHit_reg <= pageHit_next;
      lanes_reg <= lanes_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      accessDone_reg <= accessDone_next;
      readData_reg <= readData_next;
      wrStb_reg <= wrStb_next;
      fwrStb_reg <= fwrStb_next;
      rdStb_reg <= rdStb_next;
      frdStb_reg <= frdStb_next;
      latch_reg <= latch_next;
      shOut_reg <= shOut_next;
      shOe_reg <= shOe_next;
      upper_reg <= upper_next;
      cs_reg <= cs_next;
      bl_reg <= bl_next;
      busy_reg <= busy_next;
      halfLead_reg <= halfLead_next;
      halfTrail_reg <= halfTrail_next;
    end
  end

  assign accessDone = accessDone_reg;
  assign readData = readData_reg;
  assign busy = busy_reg;
  assign write_strobe_out_n = wrStb_reg;
  assign flash_write_strobe_out_n = fwrStb_reg;
  assign read_strobe_out_n = rdStb_reg;
  assign flash_read_strobe_out_n = frdStb_reg;
  assign latch_strobe_out = latch_reg;
  assign shared_addr_data_lines_out = shOut_reg;
  assign shared_addr_data_lines_oe = shOe_reg;
  assign upper_addr_lines = upper_reg;
  assign chip_select_out_n = cs_reg;
  assign byte_lane_out_n = bl_reg;
  assign strobeLeadHalfDelay = halfLead_reg;
  assign latchTrailHalfEarly = halfTrail_reg;
endmodule
`default_nettype wire

//--- shared/ebus_seq_params.svh
// Timing counts, widths and reset levels of the external bus sequencer
`ifndef EBUS_SEQ_PARAMS_SVH
`define EBUS_SEQ_PARAMS_SVH

`define EBUS_CNT_W 4
`define EBUS_ADDR_W 24
`define EBUS_DATA_W 16
`define EBUS_LANE_W 2
`define EBUS_FIFO_DEPTH 16
`define EBUS_STROBE_IDLE 1'b1
`define EBUS_SELECT_IDLE 1'b1
`define EBUS_LATCH_IDLE 1'b0
`define EBUS_CORE_CLK_PERIOD_NS 40
`define EBUS_READY_LEAD_CYCLES 3

`endif

//--- shared/ebus_seq_pkg.sv
// Types shared by the external bus sequencer
`default_nettype none
package ebus_seq_pkg;
  typedef enum logic [1:0] {
    ADDR_MODE_PLAIN,
    ADDR_MODE_MUX_BYTE_WIDE,
    ADDR_MODE_MUX_HALF_HALF
  } addr_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LATCH,
    ST_LATCH_HOLD,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } phase_t;
endpackage
`default_nettype wire

//--- rtl/ebus_req_fifo.sv
// Request FIFO with registered output stage
`default_nettype none
module ebus_req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic inReady_reg, inReady_next;
  logic outValid_reg, outValid_next;
  logic [WIDTH-1:0] outData_reg, outData_next;
  logic push, load;

  always_comb begin
    push = inValid && inReady_reg;
    load = (!outValid_reg || outReady) && (count_reg != '0);
    wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = load ? rdPtr_reg + 1'b1 : rdPtr_reg;
    count_next = count_reg;
    if (push && !load) begin
      count_next = count_reg + 1'b1;
    end else if (load && !push) begin
      count_next = count_reg - 1'b1;
    end
    // Ready registered: no combinational path from the drain side
    inReady_next = count_next != (AW + 1)'(DEPTH);
    outValid_next = outValid_reg && !outReady;
    outData_next = outData_reg;
    if (load) begin
      outValid_next = 1'b1;
      outData_next = mem[rdPtr_reg];
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady_reg <= 1'b0;
      outValid_reg <= 1'b0;
      outData_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      inReady_reg <= inReady_next;
      outValid_reg <= outValid_next;
      outData_reg <= outData_next;
    end
  end

  assign inReady = inReady_reg;
  assign outValid = outValid_reg;
  assign outData = outData_reg;
endmodule
`default_nettype wire

//--- dv/ebus_seq_props.sv
// Pin-level checker for the external bus strobe sequencer
`default_nettype none
module ebus_seq_props
  import ebus_seq_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ebus_seq_pkg::addr_mode_t addrMode,
  input wire logic readyWaitEnable,
  input wire logic pageModeEnable,
  input wire logic [CNT_W-1:0] write_strobe_cycles,
  input wire logic [CNT_W-1:0] read_strobe_cycles,
  input wire logic half_write_strobe,
  input wire logic half_read_strobe,
  input wire logic half_latch_strobe,
  input wire logic write_strobe_out_n,
  input wire logic flash_write_strobe_out_n,
  input wire logic read_strobe_out_n,
  input wire logic flash_read_strobe_out_n,
  input wire logic latch_strobe_out,
  input wire logic shared_addr_data_lines_oe,
  input wire logic chip_select_out_n,
  input wire logic accessDone,
  input wire logic strobeLeadHalfDelay,
  input wire logic latchTrailHalfEarly
);
  logic wrN;
  logic rdN;
  logic [CNT_W:0] wrLen;
  logic [CNT_W:0] rdLen;
  assign wrN = write_strobe_out_n & flash_write_strobe_out_n;
  assign rdN = read_strobe_out_n & flash_read_strobe_out_n;
  // Run length lags one edge, so it is complete when the strobe rises
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrLen <= '0;
      rdLen <= '0;
    end else begin
      wrLen <= wrN ? '0 : wrLen + 1'b1;
      rdLen <= rdN ? '0 : rdLen + 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wr_sel; !wrN |-> !chip_select_out_n && shared_addr_data_lines_oe; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
  property p_wr_len;
    $rose(wrN) && !readyWaitEnable |-> wrLen == write_strobe_cycles + 1'b1;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length");
  property p_rd_len;
    $rose(rdN) && !readyWaitEnable && !pageModeEnable |-> rdLen == read_strobe_cycles + 1'b1;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  property p_rd_sel; !rdN |-> !chip_select_out_n && !shared_addr_data_lines_oe; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read strobe bus state");
  property p_latch_mode; latch_strobe_out |-> addrMode != ADDR_MODE_PLAIN; endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("latch in plain mode");
  property p_latch_rise;
    $rose(latch_strobe_out) |-> shared_addr_data_lines_oe && !chip_select_out_n && wrN && rdN;
  endproperty
  a_latch_rise: assert property (p_latch_rise) else $error("latch start state");
  property p_half_lead;
    $rose(strobeLeadHalfDelay) |-> (half_write_strobe && $fell(wrN))
      || (half_read_strobe && $fell(rdN));
  endproperty
  a_half_lead: assert property (p_half_lead) else $error("half lead qualifier");
  property p_half_trail;
    latchTrailHalfEarly |-> half_latch_strobe && latch_strobe_out ##1 !latch_strobe_out;
  endproperty
  a_half_trail: assert property (p_half_trail) else $error("half trail qualifier");
  property p_done; accessDone |-> chip_select_out_n && wrN && rdN && !latch_strobe_out; endproperty
  a_done: assert property (p_done) else $error("done while bus active");
endmodule
bind external_bus_strobe_sequencer ebus_seq_props #(.CNT_W(CNT_W)) u_props (.*);
`default_nettype wire

//--- dv/ebus_mem_model.sv
// Far-side asynchronous memory model with optional slow ready
`default_nettype none
module ebus_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic [23:0] addr,
  input wire logic slow,
  output logic ready,
  output logic [15:0] dataOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] selCnt;
  logic [15:0] lastData;
  always_ff @(posedge core_clk) begin
    if (!rst_n || csN) begin
      selCnt <= 4'h0;
    end else if (selCnt != 4'hF) begin
      selCnt <= selCnt + 4'h1;
    end
    if (!csN) begin
      lastData <= dataOut;
    end
  end
  // Ready level set as soon as selected, well ahead of the strobe end
  assign ready = !(slow && !csN && selCnt < 4'h6);
  // Unselected lines show the inverse so stale data never matches
  assign dataOut = !csN ? (addr[15:0] ^ 16'h5A3C) : ~lastData;
endmodule
`default_nettype wire

//--- dv/tb_external_bus_strobe_sequencer.sv
// Self-checking bench for the external bus strobe sequencer
`default_nettype none
module tb_external_bus_strobe_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import ebus_seq_pkg::*;
  logic core_clk, rst_n, reqValid, reqReady, reqWrite, reqPageHit, accessDone, busy;
  logic pageModeEnable, flashStrobeSelect, readyWaitEnable, slow, ready_wait_in;
  logic half_write_strobe, half_read_strobe, half_latch_strobe, latch_strobe_out;
  logic write_strobe_out_n, flash_write_strobe_out_n, read_strobe_out_n;
  logic flash_read_strobe_out_n, shared_addr_data_lines_oe, chip_select_out_n;
  logic strobeLeadHalfDelay, latchTrailHalfEarly;
  logic [23:0] reqAddr, upper_addr_lines;
  logic [15:0] reqWriteData, readData, shared_addr_data_lines_out;
  logic [15:0] shared_addr_data_lines_in, memData;
  logic [1:0] reqByteLanes, byte_lane_out_n;
  logic [3:0] write_setup_cycles, write_strobe_cycles, write_hold_cycles;
  logic [3:0] read_setup_cycles, read_strobe_cycles, read_hold_cycles;
  logic [3:0] page_hit_strobe_cycles, latch_strobe_cycles, latch_hold_cycles;
  addr_mode_t addrMode;
  logic [15:0] nSu, nSt, nHo, nLa, n, dn;
  logic halfSeen, trailSeen, seenSt;
  logic [15:0] laneSeen, addrSeen, dataSeen;
  int err_total, n_tests, k;
  assign shared_addr_data_lines_in = shared_addr_data_lines_oe ? shared_addr_data_lines_out
                                                               : memData;
  external_bus_strobe_sequencer dut (.*);
  ebus_mem_model mem (.core_clk(core_clk), .rst_n(rst_n), .csN(chip_select_out_n),
    .addr(upper_addr_lines), .slow(slow), .ready(ready_wait_in), .dataOut(memData));
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One access, phases counted at falling edges until done
  task automatic acc(input logic wr, input logic [23:0] a, input logic ph);
    reqValid = 1;
    reqWrite = wr;
    reqAddr = a;
    reqWriteData = a[15:0];
    reqByteLanes = 2'h1;
    reqPageHit = ph;
    k = 0;
    while (reqReady !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    @(negedge core_clk);
    reqValid = 0;
    {nSu, nSt, nHo, nLa, halfSeen, trailSeen, seenSt} = '0;
    k = 0;
    while (accessDone !== 1'b1 && k < 200) begin
      if (strobeLeadHalfDelay === 1'b1) halfSeen = 1;
      if (latchTrailHalfEarly === 1'b1) trailSeen = 1;
      if (latch_strobe_out === 1'b1) begin
        nLa++;
      end else if (chip_select_out_n === 1'b0) begin
        if ((write_strobe_out_n & flash_write_strobe_out_n & read_strobe_out_n
             & flash_read_strobe_out_n) === 1'b0) begin
          nSt++;
          seenSt = 1;
          laneSeen = 16'(byte_lane_out_n);
          addrSeen = upper_addr_lines[15:0];
          dataSeen = shared_addr_data_lines_out;
        end else if (seenSt) nHo++;
        else nSu++;
      end
      @(negedge core_clk);
      k++;
    end
    chk("access done", 16'(k < 200), 16'h1);
  endtask
  initial begin
    {rst_n, reqValid, reqWrite, reqPageHit, pageModeEnable, flashStrobeSelect} = '0;
    {readyWaitEnable, slow, half_write_strobe, half_read_strobe, half_latch_strobe} = '0;
    {reqAddr, reqWriteData, reqByteLanes} = '0;
    {write_setup_cycles, write_strobe_cycles, write_hold_cycles} = {4'h2, 4'h1, 4'h3};
    {read_setup_cycles, read_strobe_cycles, read_hold_cycles} = {4'h3, 4'h2, 4'h1};
    {page_hit_strobe_cycles, latch_strobe_cycles, latch_hold_cycles} = {4'h0, 4'h1, 4'h2};
    addrMode = ADDR_MODE_PLAIN;
    repeat (6) @(negedge core_clk);
    rst_n = 1;
    @(negedge core_clk);
    acc(1, 24'h00A5C3, 0);
    chk("wr setup", nSu, 16'h2);
    chk("wr strobe", nSt, 16'h2);
    chk("wr hold", nHo, 16'h3);
    chk("plain latch", nLa, 16'h0);
    chk("wr lanes", laneSeen, 16'h2);
    chk("wr addr", addrSeen, 16'hA5C3);
    chk("wr data", dataSeen, 16'hA5C3);
    chk("no half", 16'(halfSeen), 16'h0);
    {write_setup_cycles, write_strobe_cycles, write_hold_cycles} = '0;
    {flashStrobeSelect, half_write_strobe} = 2'h3;
    acc(1, 24'h001234, 0);
    chk("zero setup", nSu, 16'h0);
    chk("min strobe", nSt, 16'h1);
    chk("zero hold", nHo, 16'h0);
    chk("half wr", 16'(halfSeen), 16'h1);
    {flashStrobeSelect, half_write_strobe, half_read_strobe, pageModeEnable} = 4'h3;
    for (int p = 0; p < 2; p++) begin
      acc(0, 24'h00C0DE + p, p[0]);
      chk("rd setup", nSu, 16'h3);
      chk("rd strobe", nSt, p ? 16'h1 : 16'h3);
      chk("rd hold", nHo, 16'h1);
      chk("half rd", 16'(halfSeen), 16'h1);
      chk("rd data", readData, (16'hC0DE + 16'(p)) ^ 16'h5A3C);
    end
    {half_read_strobe, pageModeEnable, half_latch_strobe} = 3'h1;
    write_setup_cycles = 4'h1;
    read_setup_cycles = 4'h1;
    for (int m = 1; m < 3; m++) begin
      addrMode = addr_mode_t'(m);
      for (int w = 0; w < 2; w++) begin
        acc(w[0], 24'h123456, 0);
        chk("latch len", nLa, 16'h2);
        chk("latch trail", 16'(trailSeen), 16'h1);
        chk("mux setup", nSu, w ? 16'h3 : 16'h1);
      end
    end
    addrMode = ADDR_MODE_PLAIN;
    {read_setup_cycles, read_strobe_cycles, readyWaitEnable} = {4'h3, 4'h0, 1'b1};
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      acc(0, 24'h000777, 0);
      chk("wait strobe", 16'(nSt > 16'h1), 16'(s));
    end
    {write_setup_cycles, write_strobe_cycles, write_hold_cycles} = {4'h2, 4'hF, 4'hF};
    {reqWrite, reqValid, n, dn} = {1'b1, 1'b1, 16'h0, 16'h0};
    // Short enough that no access completes, so the queue only fills
    for (int c = 0; c < 30; c++) begin
      @(negedge core_clk);
      if (reqReady === 1'b1) n++;
      reqAddr = 24'(n);
      if (accessDone === 1'b1) dn++;
    end
    reqValid = 0;
    chk("fifo full", 16'(reqReady), 16'h0);
    chk("fifo depth", 16'(n >= 16'd17 && n <= 16'd18), 16'h1);
    for (int c = 0; c < 3000 && dn < n; c++) begin
      @(negedge core_clk);
      if (accessDone === 1'b1) dn++;
    end
    chk("fifo drained", dn, n);
    chk("idle", 16'(busy), 16'h0);
    give_verdict();
  end
  initial begin
    #1ms;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
